// file: hw/dlbu_pkg.sv
// Constants for the decrement, loop and branch unit.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package dlbu_pkg;
  // Register byte offsets
  localparam logic [7:0] DLBU_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DLBU_OFS_INSN   = 8'h04;
  localparam logic [7:0] DLBU_OFS_PC     = 8'h08;
  localparam logic [7:0] DLBU_OFS_ACC_A  = 8'h0c;
  localparam logic [7:0] DLBU_OFS_ACC_B  = 8'h10;
  localparam logic [7:0] DLBU_OFS_IDX_X  = 8'h14;
  localparam logic [7:0] DLBU_OFS_IDX_Y  = 8'h18;
  localparam logic [7:0] DLBU_OFS_STACK  = 8'h1c;
  localparam logic [7:0] DLBU_OFS_FLAGS  = 8'h20;
  localparam logic [7:0] DLBU_OFS_MEM_OP = 8'h24;
  localparam logic [7:0] DLBU_OFS_MEM_RS = 8'h28;
  localparam logic [7:0] DLBU_OFS_STATUS = 8'h2c;
  // Opcodes
  localparam logic [7:0] DLBU_OPC_LOOP    = 8'h04;
  localparam logic [7:0] DLBU_OPC_DEC_A   = 8'h43;
  localparam logic [7:0] DLBU_OPC_DEC_B   = 8'h53;
  localparam logic [7:0] DLBU_OPC_DEC_IDX = 8'h63;
  localparam logic [7:0] DLBU_OPC_DEC_EXT = 8'h73;
  // Loop postbyte fields
  localparam int DLBU_LB_COND   = 5;
  localparam int DLBU_LB_SIGN   = 4;
  localparam logic [1:0] DLBU_LB_OP_DEC = 2'h0;
  localparam logic [2:0] DLBU_SEL_A  = 3'h0;
  localparam logic [2:0] DLBU_SEL_B  = 3'h1;
  localparam logic [2:0] DLBU_SEL_D  = 3'h4;
  localparam logic [2:0] DLBU_SEL_X  = 3'h5;
  localparam logic [2:0] DLBU_SEL_Y  = 3'h6;
  localparam logic [2:0] DLBU_SEL_SP = 3'h7;
  // Flag bit positions
  localparam int DLBU_FLAG_N = 3;
  localparam int DLBU_FLAG_Z = 2;
  localparam int DLBU_FLAG_V = 1;
  localparam int DLBU_FLAG_C = 0;
  // Status bit positions
  localparam int DLBU_ST_TAKEN = 0;
  localparam int DLBU_ST_UNSUP = 1;
  localparam int DLBU_ST_BUSY  = 2;
  localparam int DLBU_ST_MEMWB = 3;
  // Lengths, reset values and the byte operand whose decrement overflows
  localparam logic [15:0] DLBU_LEN_LOOP  = 16'h0003;
  localparam logic [15:0] DLBU_LEN_EXT   = 16'h0003;
  localparam logic [15:0] DLBU_LEN_INH   = 16'h0001;
  localparam logic [15:0] DLBU_RST_WORD  = 16'h0000;
  localparam logic [7:0]  DLBU_RST_BYTE  = 8'h00;
  localparam logic [7:0]  DLBU_BYTE_MIN  = 8'h80;
  typedef enum logic [1:0] {
    DLBU_IDLE = 2'b01,
    DLBU_EXEC = 2'b10
  } dlbu_state_t;
endpackage

// file: hw/dlbu_core.sv
// Decrement family executor: loop primitives and byte decrements.
// Assumes an Avalon-MM master that holds requests until waitrequest low.
//
// What this block does
// - The branch-if-zero loop decrements the counter and branches only when the result is zero.
// - Opcode 04 is three bytes; target is next instruction plus a signed 9-bit offset.
// - The branch-if-nonzero loop decrements the counter and branches only when the result is nonzero.
// - Postbyte bits 2:0 pick A, B, D, X, Y or the stack pointer as counter.
// - Postbyte bit 5 clear branches on zero, set branches on nonzero.
// - Postbyte bit 4 is the sign bit placed above the eight offset bits.
// - Postbyte bit 3 is ignored.
// - Postbyte bits 7:6 equal to 00 select the decrement operation.
// - Memory decrement reads a byte, subtracts one and writes it back, opcodes 73 and 63.
// - Byte decrements set N from result bit 7 and Z when the result is 00.
// - Byte decrements set V exactly when the operand was 80.
// - Byte decrements leave the carry flag unchanged.
// - Opcode 43 decrements accumulator A and updates N, Z and V.
// - Opcode 53 decrements accumulator B and updates N, Z and V.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module dlbu_core
  import dlbu_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             mem_wb_valid_out,
  output logic [7:0]       mem_wb_data_out
);
  import dlbu_pkg::*;

  dlbu_state_t state;
  logic        ack;
  logic [23:0] insn;
  logic [15:0] pc;
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [15:0] idx_x;
  logic [15:0] idx_y;
  logic [15:0] stack;
  logic [7:0]  condition_flags;
  logic [7:0]  mem_op;
  logic [7:0]  mem_rs;
  logic        st_taken;
  logic        st_unsup;
  logic        st_memwb;
  logic [31:0] rdata;

  // Bus handshake: every request waits exactly one cycle
  wire         req      = avs_read_in | avs_write_in;
  wire         wr_acc   = avs_write_in & ack;
  wire [31:0]  bmask    = {{8{avs_byteenable_in[3]}},
                           {8{avs_byteenable_in[2]}},
                           {8{avs_byteenable_in[1]}},
                           {8{avs_byteenable_in[0]}}};
  wire         wr_ctrl  = wr_acc & (avs_address_in == DLBU_OFS_CTRL);
  wire         wr_insn  = wr_acc & (avs_address_in == DLBU_OFS_INSN);
  wire         wr_pc    = wr_acc & (avs_address_in == DLBU_OFS_PC);
  wire         wr_a     = wr_acc & (avs_address_in == DLBU_OFS_ACC_A);
  wire         wr_b     = wr_acc & (avs_address_in == DLBU_OFS_ACC_B);
  wire         wr_x     = wr_acc & (avs_address_in == DLBU_OFS_IDX_X);
  wire         wr_y     = wr_acc & (avs_address_in == DLBU_OFS_IDX_Y);
  wire         wr_sp    = wr_acc & (avs_address_in == DLBU_OFS_STACK);
  wire         wr_flags = wr_acc & (avs_address_in == DLBU_OFS_FLAGS);
  wire         wr_memop = wr_acc & (avs_address_in == DLBU_OFS_MEM_OP);
  wire         go       = wr_ctrl & avs_byteenable_in[0]
                          & avs_writedata_in[0];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Instruction field decode
  wire [7:0]  opcode   = insn[7:0];
  wire [7:0]  loop_postbyte = insn[15:8];
  wire [7:0]  off_low  = insn[23:16];
  wire        exec     = (state == DLBU_EXEC);
  wire [2:0]  sel      = loop_postbyte[2:0];
  wire        is_loop  = opcode == DLBU_OPC_LOOP;
  wire        loop_dec = loop_postbyte[7:6] == DLBU_LB_OP_DEC;
  wire        sel_ok   = (sel == DLBU_SEL_A) | (sel == DLBU_SEL_B)
                         | (sel[2] == 1'b1);
  wire        do_loop  = is_loop & loop_dec & sel_ok;
  wire        is_dec_a = opcode == DLBU_OPC_DEC_A;
  wire        is_dec_b = opcode == DLBU_OPC_DEC_B;
  wire        is_dec_m = (opcode == DLBU_OPC_DEC_EXT)
                         | (opcode == DLBU_OPC_DEC_IDX);
  wire        is_byte  = is_dec_a | is_dec_b | is_dec_m;
  wire        unsup    = ~(do_loop | is_byte);

  // Loop counter path
  wire [15:0] cnt_val  = (sel == DLBU_SEL_A)  ? {8'h00, acc_a} :
                         (sel == DLBU_SEL_B)  ? {8'h00, acc_b} :
                         (sel == DLBU_SEL_D)  ? {acc_a, acc_b} :
                         (sel == DLBU_SEL_X)  ? idx_x :
                         (sel == DLBU_SEL_Y)  ? idx_y : stack;
  wire [15:0] cnt_dec  = cnt_val - 16'h0001;
  // Byte counters wrap at 8 bits, so only the low byte is tested
  wire        cnt_zero = sel[2] ? (cnt_dec == 16'h0000)
                                : (cnt_dec[7:0] == 8'h00);
  wire        take     = loop_postbyte[DLBU_LB_COND] ? ~cnt_zero
                                                     : cnt_zero;
  wire [15:0] offset9  = {{7{loop_postbyte[DLBU_LB_SIGN]}},
                          loop_postbyte[DLBU_LB_SIGN], off_low};
  wire [15:0] pc_next  = pc + DLBU_LEN_LOOP;
  wire [15:0] pc_loop  = take ? pc_next + offset9 : pc_next;

  // Byte decrement path
  wire [7:0]  byte_src = is_dec_a ? acc_a :
                         is_dec_b ? acc_b : mem_op;
  wire [7:0]  byte_res = byte_src - 8'h01;
  wire        res_n    = byte_res[7];
  wire        res_z    = byte_res == 8'h00;
  wire        res_v    = byte_src == DLBU_BYTE_MIN;
  wire [7:0]  flags_dec = {condition_flags[7:4], res_n, res_z, res_v,
                           condition_flags[DLBU_FLAG_C]};
  // Indexed forms have variable length; the core leaves PC unchanged for them
  wire [15:0] pc_byte  = (is_dec_a | is_dec_b) ? pc + DLBU_LEN_INH :
                         (opcode == DLBU_OPC_DEC_EXT) ?
                         pc + DLBU_LEN_EXT : pc;

  // Selected-counter write strobes
  wire        ld_cnt   = exec & do_loop;
  wire        ld_a     = ld_cnt & ((sel == DLBU_SEL_A) | (sel == DLBU_SEL_D));
  wire        ld_b     = ld_cnt & ((sel == DLBU_SEL_B) | (sel == DLBU_SEL_D));
  wire [7:0]  loop_a   = (sel == DLBU_SEL_D) ? cnt_dec[15:8] : cnt_dec[7:0];

  wire [7:0]  next_a   = (exec & is_dec_a) ? byte_res :
                         ld_a ? loop_a :
                         wr_a ? 8'(merge({24'h0, acc_a},
                                 avs_writedata_in, bmask)) : acc_a;
  wire [7:0]  next_b   = (exec & is_dec_b) ? byte_res :
                         ld_b ? cnt_dec[7:0] :
                         wr_b ? 8'(merge({24'h0, acc_b},
                                 avs_writedata_in, bmask)) : acc_b;
  wire [15:0] next_x   = (ld_cnt & (sel == DLBU_SEL_X)) ? cnt_dec :
                         wr_x ? 16'(merge({16'h0, idx_x},
                                 avs_writedata_in, bmask)) : idx_x;
  wire [15:0] next_y   = (ld_cnt & (sel == DLBU_SEL_Y)) ? cnt_dec :
                         wr_y ? 16'(merge({16'h0, idx_y},
                                 avs_writedata_in, bmask)) : idx_y;
  wire [15:0] next_sp  = (ld_cnt & (sel == DLBU_SEL_SP)) ? cnt_dec :
                         wr_sp ? 16'(merge({16'h0, stack},
                                 avs_writedata_in, bmask)) : stack;
  wire [15:0] next_pc  = ld_cnt ? pc_loop :
                         (exec & is_byte) ? pc_byte :
                         wr_pc ? 16'(merge({16'h0, pc},
                                 avs_writedata_in, bmask)) : pc;
  // Loops leave flags alone; only byte decrements touch them
  wire [7:0]  next_flags = (exec & is_byte) ? flags_dec :
                           wr_flags ? 8'(merge({24'h0, condition_flags},
                                     avs_writedata_in, bmask))
                                    : condition_flags;
  wire [23:0] next_insn  = wr_insn ? 24'(merge({8'h0, insn},
                                     avs_writedata_in, bmask)) : insn;
  wire [7:0]  next_memop = wr_memop ? 8'(merge({24'h0, mem_op},
                                     avs_writedata_in, bmask)) : mem_op;

  wire [31:0] status_w = {28'h0, st_memwb, exec, st_unsup, st_taken};
  wire [31:0] rd_mux   =
    (avs_address_in == DLBU_OFS_INSN)   ? {8'h0, insn} :
    (avs_address_in == DLBU_OFS_PC)     ? {16'h0, pc} :
    (avs_address_in == DLBU_OFS_ACC_A)  ? {24'h0, acc_a} :
    (avs_address_in == DLBU_OFS_ACC_B)  ? {24'h0, acc_b} :
    (avs_address_in == DLBU_OFS_IDX_X)  ? {16'h0, idx_x} :
    (avs_address_in == DLBU_OFS_IDX_Y)  ? {16'h0, idx_y} :
    (avs_address_in == DLBU_OFS_STACK)  ? {16'h0, stack} :
    (avs_address_in == DLBU_OFS_FLAGS)  ? {24'h0, condition_flags} :
    (avs_address_in == DLBU_OFS_MEM_OP) ? {24'h0, mem_op} :
    (avs_address_in == DLBU_OFS_MEM_RS) ? {24'h0, mem_rs} :
    (avs_address_in == DLBU_OFS_STATUS) ? status_w : 32'h0000_0000;

  assign avs_waitrequest_out = req & ~ack;
  assign avs_readdata_out    = rdata;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= req & ~ack;
      if (avs_read_in & ~ack)
        rdata <= rd_mux;
    end
  end

  // One execute cycle follows each accepted go; no bus write can land then
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      state <= DLBU_IDLE;
    else
    begin
      unique case (state)
        DLBU_IDLE: state <= go ? DLBU_EXEC : DLBU_IDLE;
        DLBU_EXEC: state <= DLBU_IDLE;
        default:   state <= DLBU_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      insn            <= 24'h00_0000;
      pc              <= DLBU_RST_WORD;
      acc_a           <= DLBU_RST_BYTE;
      acc_b           <= DLBU_RST_BYTE;
      idx_x           <= DLBU_RST_WORD;
      idx_y           <= DLBU_RST_WORD;
      stack           <= DLBU_RST_WORD;
      condition_flags <= DLBU_RST_BYTE;
      mem_op          <= DLBU_RST_BYTE;
    end
    else
    begin
      insn            <= next_insn;
      pc              <= next_pc;
      acc_a           <= next_a;
      acc_b           <= next_b;
      idx_x           <= next_x;
      idx_y           <= next_y;
      stack           <= next_sp;
      condition_flags <= next_flags;
      mem_op          <= next_memop;
    end
  end

  // Result of the last memory decrement and status of the last executed instruction
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      mem_rs           <= DLBU_RST_BYTE;
      st_taken         <= 1'b0;
      st_unsup         <= 1'b0;
      st_memwb         <= 1'b0;
      mem_wb_valid_out <= 1'b0;
      mem_wb_data_out  <= DLBU_RST_BYTE;
    end
    else
    begin
      mem_wb_valid_out <= exec & is_dec_m;
      if (exec)
      begin
        st_taken <= do_loop & take;
        st_unsup <= unsup;
        st_memwb <= is_dec_m;
        if (is_dec_m)
        begin
          mem_rs          <= byte_res;
          mem_wb_data_out <= byte_res;
        end
      end
    end
  end
endmodule // dlbu_core

// file: tb/dlbu_mem_model.sv
// Memory byte on the write-back side of the decrement unit.
// Assumes a one-clock write-back pulse that carries its byte.
`timescale 1ns/10ps
module dlbu_mem_model
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       wb_valid_in,
  input  wire logic [7:0] wb_data_in,
  output logic [7:0]      mem_byte_out,
  output logic [7:0]      wb_count_out
);
  // Counting pulses exposes a doubled or missing write-back
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      mem_byte_out <= 8'h00;
      wb_count_out <= 8'h00;
    end
    else if (wb_valid_in)
    begin
      mem_byte_out <= wb_data_in;
      wb_count_out <= wb_count_out + 8'h01;
    end
  end
endmodule // dlbu_mem_model

// file: tb/dlbu_core_chk.sv
// Checker for the bus handshake and memory write-back ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module dlbu_core_chk
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        mem_wb_valid_out,
  input wire logic [7:0]  mem_wb_data_out
);
  import dlbu_pkg::*;
  logic [7:0] op_sh;
  logic [7:0] mem_sh;
  wire req = avs_read_in | avs_write_in;
  wire wr_ok = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  wire go = wr_ok & (avs_address_in == DLBU_OFS_CTRL) & avs_writedata_in[0];
  wire is_mem = (op_sh == DLBU_OPC_DEC_EXT) | (op_sh == DLBU_OPC_DEC_IDX);
  wire mem_go = go & is_mem;
  // Shadows of the opcode and operand last accepted on the bus
  always_ff @(posedge clk_in)
  begin
    if (wr_ok && avs_address_in == DLBU_OFS_INSN)
      op_sh <= avs_writedata_in[7:0];
    if (wr_ok && avs_address_in == DLBU_OFS_MEM_OP)
      mem_sh <= avs_writedata_in[7:0];
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_mem_go;
    mem_go;
  endsequence
  sequence s_wb_pulse;
    mem_wb_valid_out ##1 !mem_wb_valid_out;
  endsequence
  property p_wait_first;
    $rose(req) |-> avs_waitrequest_out;
  endproperty
  property p_wait_bound;
    req |-> ##[0:1] !avs_waitrequest_out;
  endproperty
  property p_wait_idle;
    !req |-> !avs_waitrequest_out;
  endproperty
  property p_wb_one;
    mem_wb_valid_out |=> !mem_wb_valid_out;
  endproperty
  property p_wb_hold;
    !mem_wb_valid_out |-> $stable(mem_wb_data_out);
  endproperty
  property p_wb_cause;
    mem_wb_valid_out |-> $past(mem_go, 2);
  endproperty
  property p_wb_data;
    mem_wb_valid_out |-> mem_wb_data_out == mem_sh - 8'h01;
  endproperty
  property p_wb_after_go;
    s_mem_go |-> ##1 !mem_wb_valid_out ##1 s_wb_pulse;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("waitrequest low on a new request");
  a_wait_bound: assert property (p_wait_bound)
    else $error("request not answered in one wait cycle");
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest high with no request");
  a_wb_one: assert property (p_wb_one)
    else $error("write-back pulse longer than one cycle");
  a_wb_hold: assert property (p_wb_hold)
    else $error("write-back byte changed without a pulse");
  a_wb_cause: assert property (p_wb_cause)
    else $error("write-back without a memory decrement");
  a_wb_data: assert property (p_wb_data)
    else $error("write-back byte is not operand minus one");
  a_wb_after_go: assert property (p_wb_after_go)
    else $error("memory decrement gave no timely write-back");
endmodule // dlbu_core_chk

// file: tb/tb_top.sv
// Self-checking bench for the decrement unit over its register bus.
// Assumes the 25 MHz clock and the register map of the package.
`timescale 1ns/10ps
module tb_top;
  import dlbu_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        mem_wb_valid_out;
  logic [7:0]  mem_wb_data_out;
  logic [7:0]  wb_byte;
  logic [7:0]  wb_count;
  logic [31:0] rd;
  int          num_errors = 0;
  int          num_checks = 0;
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  dlbu_core i_dlbu_core (.clk_in(clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .mem_wb_valid_out(mem_wb_valid_out), .mem_wb_data_out(mem_wb_data_out));
  dlbu_mem_model i_dlbu_mem_model (.clk_in(clk_in), .reset_in(reset_in),
    .wb_valid_in(mem_wb_valid_out), .wb_data_in(mem_wb_data_out),
    .mem_byte_out(wb_byte), .wb_count_out(wb_count));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then one idle edge
  // No local limit: a stalled slave is left to the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    do
      @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic go(input logic [31:0] insn);
    wr(DLBU_OFS_INSN, insn);
    wr(DLBU_OFS_CTRL, 32'h0000_0001);
  endtask
  task automatic set_regs(input logic [7:0] a, b,
    input logic [15:0] x, y, sp, pc, input logic [7:0] f);
    wr(DLBU_OFS_ACC_A, {24'h00_0000, a});
    wr(DLBU_OFS_ACC_B, {24'h00_0000, b});
    wr(DLBU_OFS_IDX_X, {16'h0000, x});
    wr(DLBU_OFS_IDX_Y, {16'h0000, y});
    wr(DLBU_OFS_STACK, {16'h0000, sp});
    wr(DLBU_OFS_PC, {16'h0000, pc});
    wr(DLBU_OFS_FLAGS, {24'h00_0000, f});
  endtask
  task automatic t_reset_map();
    rdc(DLBU_OFS_PC, 32'h0000_0000);
    rdc(DLBU_OFS_FLAGS, 32'h0000_0000);
    wr(8'h30, 32'h0000_00ff);
    rdc(8'h30, 32'h0000_0000);
    wr(DLBU_OFS_STATUS, 32'h0000_000f);
    rdc(DLBU_OFS_STATUS, 32'h0000_0000);
  endtask
  task automatic t_loop_sel();
    logic [2:0] sel [6] = '{DLBU_SEL_A, DLBU_SEL_B, DLBU_SEL_D,
      DLBU_SEL_X, DLBU_SEL_Y, DLBU_SEL_SP};
    logic [7:0] ra [6] = '{DLBU_OFS_ACC_A, DLBU_OFS_ACC_B, DLBU_OFS_ACC_B,
      DLBU_OFS_IDX_X, DLBU_OFS_IDX_Y, DLBU_OFS_STACK};
    logic       hi;
    for (int i = 0; i < 6; i++)
    begin
      hi = (sel[i] != DLBU_SEL_A) && (sel[i] != DLBU_SEL_D);
      set_regs({7'h00, sel[i] != DLBU_SEL_D}, 8'h01, 16'h0001, 16'h0001,
        16'h0001, 16'h1000, 8'h00);
      go({16'h0000, 5'h02, sel[i], DLBU_OPC_LOOP});
      rdc(ra[i], 32'h0000_0000);
      rdc(DLBU_OFS_ACC_A, {31'h0000_0000, hi});
      rdc(DLBU_OFS_PC, 32'h0000_0f03);
      rdc(DLBU_OFS_STATUS, 32'h0000_0001);
    end
  endtask
  task automatic t_loop_wide();
    set_regs(8'h01, 8'h00, 16'h0101, 16'h0000, 16'h0000, 16'h2000, 8'ha5);
    go({8'h00, 8'hff, 8'h2c, DLBU_OPC_LOOP});
    rdc(DLBU_OFS_ACC_A, 32'h0000_0000);
    rdc(DLBU_OFS_ACC_B, 32'h0000_00ff);
    rdc(DLBU_OFS_PC, 32'h0000_2102);
    rdc(DLBU_OFS_FLAGS, 32'h0000_00a5);
    go({8'h00, 8'h40, 8'h05, DLBU_OPC_LOOP});
    // Low byte reaches zero, full word does not: no branch
    rdc(DLBU_OFS_IDX_X, 32'h0000_0100);
    rdc(DLBU_OFS_PC, 32'h0000_2105);
    rdc(DLBU_OFS_STATUS, 32'h0000_0000);
  endtask
  task automatic t_unsup();
    set_regs(8'h05, 8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h2000, 8'h00);
    for (int k = 1; k < 4; k++)
    begin
      go({16'h0000, k[1:0], 6'h20, DLBU_OPC_LOOP});
      rdc(DLBU_OFS_ACC_A, 32'h0000_0005);
      rdc(DLBU_OFS_STATUS, 32'h0000_0002);
    end
    go({16'h0000, 8'h22, DLBU_OPC_LOOP});
    rdc(DLBU_OFS_STATUS, 32'h0000_0002);
    rdc(DLBU_OFS_PC, 32'h0000_2000);
    rdc(DLBU_OFS_ACC_A, 32'h0000_0005);
  endtask
  task automatic t_dec_acc();
    set_regs(8'h80, 8'h01, 16'h0000, 16'h0000, 16'h0000, 16'h3000, 8'hf1);
    go({24'h00_0000, DLBU_OPC_DEC_A});
    rdc(DLBU_OFS_ACC_A, 32'h0000_007f);
    rdc(DLBU_OFS_FLAGS, 32'h0000_00f3);
    go({24'h00_0000, DLBU_OPC_DEC_B});
    rdc(DLBU_OFS_ACC_B, 32'h0000_0000);
    rdc(DLBU_OFS_FLAGS, 32'h0000_00f5);
    rdc(DLBU_OFS_PC, 32'h0000_3002);
  endtask
  task automatic t_dec_mem();
    set_regs(8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h4000, 8'h00);
    wr(DLBU_OFS_MEM_OP, 32'h0000_0000);
    go({24'h00_0000, DLBU_OPC_DEC_EXT});
    // Write-back lands one edge after go returns; read first
    rdc(DLBU_OFS_MEM_RS, 32'h0000_00ff);
    check({24'h00_0000, wb_byte}, 32'h0000_00ff);
    rdc(DLBU_OFS_FLAGS, 32'h0000_0008);
    rdc(DLBU_OFS_STATUS, 32'h0000_0008);
    wr(DLBU_OFS_MEM_OP, 32'h0000_0080);
    go({24'h00_0000, DLBU_OPC_DEC_IDX});
    rdc(DLBU_OFS_FLAGS, 32'h0000_0002);
    check({24'h00_0000, wb_byte}, 32'h0000_007f);
    rdc(DLBU_OFS_PC, 32'h0000_4003);
    check({24'h00_0000, wb_count}, 32'h0000_0002);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    reset_in = 1'b1;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'hf;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    t_reset_map();
    t_loop_sel();
    t_loop_wide();
    t_unsup();
    t_dec_acc();
    t_dec_mem();
    print_verdict();
  end
endmodule // tb_top
bind dlbu_core dlbu_core_chk i_dlbu_core_chk (.clk_in(clk_in),
  .reset_in(reset_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .mem_wb_valid_out(mem_wb_valid_out), .mem_wb_data_out(mem_wb_data_out));
